// ### core/ecpt_prescaler.sv
package ecpt_pkg;
   // -------------------------------------------------------------
   // Register offsets (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] ECPT_OFF_COUNT = 8'h00;
   localparam logic [7:0] ECPT_OFF_CONST_A = 8'h04;
   localparam logic [7:0] ECPT_OFF_CONST_B = 8'h08;
   localparam logic [7:0] ECPT_OFF_CTRL0 = 8'h0c;
   localparam logic [7:0] ECPT_OFF_STATUS = 8'h10;
   localparam logic [7:0] ECPT_OFF_CTRL1 = 8'h14;
   localparam logic [7:0] ECPT_OFF_MASK = 8'h18;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int ECPT_ST_MATCH_B = 7;
   localparam int ECPT_ST_MATCH_A = 6;
   localparam int ECPT_ST_OVF = 5;
   localparam int ECPT_ST_OSB_HI = 3;
   localparam int ECPT_ST_OSB_LO = 2;
   localparam int ECPT_ST_OSA_HI = 1;
   localparam int ECPT_ST_OSA_LO = 0;
   localparam int ECPT_C0_CLR_HI = 4;
   localparam int ECPT_C0_CLR_LO = 3;
   localparam int ECPT_C0_CKS_HI = 2;
   localparam int ECPT_C0_CKS_LO = 0;
   localparam int ECPT_C1_TEDGE_HI = 4;
   localparam int ECPT_C1_TEDGE_LO = 3;
   localparam int ECPT_C1_TRIGGER_START_ENABLE = 2;
   localparam int ECPT_C1_ICKS = 0;
   // -------------------------------------------------------------
   // Reset values, read and write masks
   // -------------------------------------------------------------
   localparam logic [7:0] ECPT_RST_CONST = 8'hff;
   localparam logic [7:0] ECPT_RST_REG = 8'h00;
   localparam logic [7:0] ECPT_C1_RSVD_ONES = 8'he2;
   localparam logic [7:0] ECPT_C0_WMASK = 8'h1f;
   localparam logic [7:0] ECPT_C1_WMASK = 8'h1d;
   localparam logic [7:0] ECPT_FLAG_MASK = 8'he0;
   localparam logic [7:0] ECPT_OS_MASK = 8'h0f;
   localparam logic [7:0] ECPT_CNT_MAX = 8'hff;
   // -------------------------------------------------------------
   // Encodings
   // -------------------------------------------------------------
   localparam logic [1:0] ECPT_OS_NONE = 2'h0;
   localparam logic [1:0] ECPT_OS_LOW = 2'h1;
   localparam logic [1:0] ECPT_OS_HIGH = 2'h2;
   localparam logic [1:0] ECPT_OS_TOGGLE = 2'h3;
   localparam logic [1:0] ECPT_CLR_NONE = 2'h0;
   localparam logic [1:0] ECPT_CLR_MATCH_A = 2'h1;
   localparam logic [1:0] ECPT_CLR_MATCH_B = 2'h2;
   localparam logic [1:0] ECPT_CLR_PIN = 2'h3;
   localparam logic [1:0] ECPT_EDGE_NONE = 2'h0;
   localparam logic [1:0] ECPT_EDGE_RISE = 2'h1;
   localparam logic [1:0] ECPT_EDGE_FALL = 2'h2;
   localparam logic [1:0] ECPT_EDGE_BOTH = 2'h3;
   localparam logic [2:0] ECPT_CKS_STOP = 3'h0;
   localparam logic [2:0] ECPT_CKS_EXT_RISE = 3'h5;
   localparam logic [2:0] ECPT_CKS_EXT_FALL = 3'h6;
   localparam logic [2:0] ECPT_CKS_EXT_BOTH = 3'h7;
   localparam int ECPT_PRESC_W = 6;
endpackage : ecpt_pkg

`timescale 1ns/100ps

// -------------------------------------------------------------
// Free running divider of the system clock
// -------------------------------------------------------------
module ecpt_prescaler
   import ecpt_pkg::*;
#(
   parameter int WIDTH = ECPT_PRESC_W
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic [WIDTH-1:0] taps
);
   logic [WIDTH-1:0] div_ff;
   logic [WIDTH-1:0] nxt_div;

   assign nxt_div = div_ff + {{(WIDTH-1){1'b0}}, 1'b1};
   assign taps = div_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= '0;
      end else begin
         div_ff <= nxt_div;
      end
   end
endmodule : ecpt_prescaler

// ### core/ecpt_timer.sv
// Notes on behaviour
// RULE1: Clear event during a counter write wins; written value is discarded.
// RULE2: Counter write during an increment wins; that increment is dropped.
// RULE3: Compare constant write suppresses its match: no flag, no output change.
// RULE4: Simultaneous matches resolve output as toggle, then high, then low.
// RULE5: Internal source increments on falling edge of selected divided clock.
// RULE6: Switching internal source from high to low level counts once.
// RULE7: Switching between internal and external source may count once.
// RULE8: Clear on A, high on A, low on B gives free PWM waveform.
// RULE9: Clear on B with trigger start gives delayed single pulses.
// RULE10: Clock source chosen by clock select field plus internal clock bit.
// RULE11: Output select codes: none, low, high, toggle on its match.
// RULE12: Rollover from max to zero sets overflow flag and may interrupt.
// RULE13: With trigger start, clear halts counting until selected trigger edge.
// RULE14: Output pin is low after reset until first compare match.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps

module ecpt_timer
   import ecpt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clock_pin,
   input wire logic counter_reset_pin,
   input wire logic trigger_input_pin,
   output logic pulse_output_pin,
   output logic irq
);
   // -------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------
   function automatic logic edge_hit(input logic prev, input logic cur,
                                     input logic [1:0] sel);
      logic rise;
      logic fall;
      rise = !prev && cur;
      fall = prev && !cur;
      unique case (sel)
         ECPT_EDGE_RISE: edge_hit = rise;
         ECPT_EDGE_FALL: edge_hit = fall;
         ECPT_EDGE_BOTH: edge_hit = rise || fall;
         default: edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   function automatic logic [3:0] os_mask(input logic hit, input logic [1:0] os);
      os_mask = 4'h0;
      if (hit) begin
         os_mask[os] = 1'b1;
      end
   endfunction : os_mask

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   logic [7:0] count_value_ff;
   logic [7:0] compare_constant_a_ff;
   logic [7:0] compare_constant_b_ff;
   logic [7:0] control_reg_zero_ff;
   logic [7:0] control_reg_one_ff;
   logic [2:0] flags_ff;
   logic [3:0] out_sel_ff;
   logic [2:0] int_mask_ff;
   logic pulse_out_ff;
   logic run_ff;
   logic src_lvl_ff;
   logic ext_prev_ff;
   logic trig_prev_ff;
   logic clrpin_prev_ff;

   logic [7:0] nxt_count;
   logic [2:0] nxt_flags;
   logic nxt_pulse_out;
   logic nxt_run;

   // -------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire hit_cnt = paddr == ECPT_OFF_COUNT;
   wire hit_ca = paddr == ECPT_OFF_CONST_A;
   wire hit_cb = paddr == ECPT_OFF_CONST_B;
   wire hit_c0 = paddr == ECPT_OFF_CTRL0;
   wire hit_st = paddr == ECPT_OFF_STATUS;
   wire hit_c1 = paddr == ECPT_OFF_CTRL1;
   wire hit_mk = paddr == ECPT_OFF_MASK;
   wire mapped = hit_cnt || hit_ca || hit_cb || hit_c0 || hit_st || hit_c1 || hit_mk;
   wire wr_cnt = wr && hit_cnt;
   wire wr_ca = wr && hit_ca;
   wire wr_cb = wr && hit_cb;
   wire wr_c0 = wr && hit_c0;
   wire wr_st = wr && hit_st;
   wire wr_c1 = wr && hit_c1;
   wire wr_mk = wr && hit_mk;
   wire [7:0] wbyte = pwdata[7:0];

   assign pready = 1'b1;
   assign pslverr = acc && !mapped;

   // -------------------------------------------------------------
   // Control fields
   // -------------------------------------------------------------
   wire [1:0] clear_sel = control_reg_zero_ff[ECPT_C0_CLR_HI:ECPT_C0_CLR_LO];
   wire [2:0] clock_sel = control_reg_zero_ff[ECPT_C0_CKS_HI:ECPT_C0_CKS_LO];
   wire [1:0] trig_edge = control_reg_one_ff[ECPT_C1_TEDGE_HI:ECPT_C1_TEDGE_LO];
   wire trigger_start_enable = control_reg_one_ff[ECPT_C1_TRIGGER_START_ENABLE];
   wire internal_clock_sel = control_reg_one_ff[ECPT_C1_ICKS];
   wire [1:0] out_sel_a = out_sel_ff[ECPT_ST_OSA_HI:ECPT_ST_OSA_LO];
   wire [1:0] out_sel_b = out_sel_ff[ECPT_ST_OSB_HI:ECPT_ST_OSB_LO];

   // -------------------------------------------------------------
   // Count source
   // -------------------------------------------------------------
   logic [ECPT_PRESC_W-1:0] taps;

   ecpt_prescaler #(
      .WIDTH(ECPT_PRESC_W)
   ) u_presc (
      .pclk(pclk),
      .presetn(presetn),
      .taps(taps)
   );

   // Codes 1..3 with the internal bit pick one of six divided clocks
   wire [2:0] cks_m1 = clock_sel - 3'h1;
   wire [2:0] tap_idx = {cks_m1[1:0], internal_clock_sel}; // RULE10
   wire is_ext = clock_sel >= ECPT_CKS_EXT_RISE;
   wire is_int = !is_ext && clock_sel != ECPT_CKS_STOP && clock_sel != 3'h4;
   wire int_lvl = (tap_idx < 3'(ECPT_PRESC_W)) ? taps[tap_idx] : 1'b0; // RULE10
   // External rising is inverted so a falling detector serves every single-edge source
   wire src_lvl = is_int ? int_lvl
                : (clock_sel == ECPT_CKS_EXT_RISE) ? !ext_clock_pin
                : (clock_sel == ECPT_CKS_EXT_FALL) ? ext_clock_pin
                : (clock_sel == ECPT_CKS_EXT_BOTH) ? ext_clock_pin : 1'b0;
   // One stored level across sources: a switch from high to low counts
   wire fall_tick = src_lvl_ff && !src_lvl && (is_int || is_ext); // RULE5 RULE6 RULE7
   wire both_tick = (clock_sel == ECPT_CKS_EXT_BOTH) && (src_lvl_ff != src_lvl);
   wire running = !trigger_start_enable || run_ff; // RULE13
   wire inc = (fall_tick || both_tick) && running;

   // -------------------------------------------------------------
   // Compare and clear
   // -------------------------------------------------------------
   wire eq_a = count_value_ff == compare_constant_a_ff;
   wire eq_b = count_value_ff == compare_constant_b_ff;
   // Match fires in the last state of equality, i.e. as the count moves on
   wire match_a = eq_a && inc && !wr_ca; // RULE3
   wire match_b = eq_b && inc && !wr_cb; // RULE3
   wire clrpin_rise = !clrpin_prev_ff && counter_reset_pin;
   wire clear_ev = (clear_sel == ECPT_CLR_MATCH_A && match_a)
                || (clear_sel == ECPT_CLR_MATCH_B && match_b)
                || (clear_sel == ECPT_CLR_PIN && clrpin_rise); // RULE8 RULE9
   wire trig_ev = edge_hit(trig_prev_ff, trigger_input_pin, trig_edge);
   wire ovf_ev = inc && !clear_ev && !wr_cnt && count_value_ff == ECPT_CNT_MAX;

   always_comb begin
      nxt_count = count_value_ff;
      if (clear_ev) begin
         nxt_count = '0; // RULE1
      end else if (wr_cnt) begin
         nxt_count = wbyte; // RULE2
      end else if (inc) begin
         nxt_count = count_value_ff + 8'h01;
      end
   end

   always_comb begin
      nxt_run = run_ff;
      if (clear_ev) begin
         nxt_run = 1'b0; // RULE13
      end else if (trig_ev) begin
         nxt_run = 1'b1; // RULE13 RULE9
      end
   end

   // -------------------------------------------------------------
   // Output pin
   // -------------------------------------------------------------
   wire [3:0] act = os_mask(match_a, out_sel_a) | os_mask(match_b, out_sel_b); // RULE11

   always_comb begin
      nxt_pulse_out = pulse_out_ff;
      if (act[ECPT_OS_TOGGLE]) begin
         nxt_pulse_out = !pulse_out_ff; // RULE4
      end else if (act[ECPT_OS_HIGH]) begin
         nxt_pulse_out = 1'b1; // RULE4 RULE8
      end else if (act[ECPT_OS_LOW]) begin
         nxt_pulse_out = 1'b0; // RULE4 RULE8
      end
   end

   assign pulse_output_pin = pulse_out_ff;

   // -------------------------------------------------------------
   // Flags and interrupt
   // -------------------------------------------------------------
   wire [2:0] set_flags = {match_b, match_a, ovf_ev}; // RULE12
   wire [2:0] clr_flags = wr_st ? wbyte[ECPT_ST_MATCH_B:ECPT_ST_OVF] : 3'h0;

   assign nxt_flags = (flags_ff & ~clr_flags) | set_flags;
   assign irq = |(flags_ff & int_mask_ff); // RULE12

   // -------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------
   wire [7:0] status_rd = {flags_ff, 1'b0, out_sel_ff};
   wire [7:0] rd_byte = hit_cnt ? count_value_ff
                      : hit_ca ? compare_constant_a_ff
                      : hit_cb ? compare_constant_b_ff
                      : hit_c0 ? control_reg_zero_ff
                      : hit_st ? status_rd
                      : hit_c1 ? (control_reg_one_ff | ECPT_C1_RSVD_ONES)
                      : hit_mk ? {int_mask_ff, 5'h00} : 8'h00;

   assign prdata = {24'h000000, rd_byte};

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value_ff <= ECPT_RST_REG;
         run_ff <= 1'b0;
         flags_ff <= 3'h0;
         pulse_out_ff <= 1'b0; // RULE14
      end else begin
         count_value_ff <= nxt_count;
         run_ff <= nxt_run;
         flags_ff <= nxt_flags;
         pulse_out_ff <= nxt_pulse_out;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_lvl_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
         trig_prev_ff <= 1'b0;
         clrpin_prev_ff <= 1'b0;
      end else begin
         src_lvl_ff <= src_lvl;
         ext_prev_ff <= ext_clock_pin;
         trig_prev_ff <= trigger_input_pin;
         clrpin_prev_ff <= counter_reset_pin;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_constant_a_ff <= ECPT_RST_CONST;
         compare_constant_b_ff <= ECPT_RST_CONST;
      end else begin
         if (wr_ca) begin
            compare_constant_a_ff <= wbyte; // RULE3
         end
         if (wr_cb) begin
            compare_constant_b_ff <= wbyte; // RULE3
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_reg_zero_ff <= ECPT_RST_REG;
         control_reg_one_ff <= ECPT_RST_REG;
         out_sel_ff <= 4'h0;
         int_mask_ff <= 3'h0;
      end else begin
         if (wr_c0) begin
            control_reg_zero_ff <= wbyte & ECPT_C0_WMASK;
         end
         if (wr_c1) begin
            control_reg_one_ff <= wbyte & ECPT_C1_WMASK;
         end
         if (wr_st) begin
            out_sel_ff <= wbyte[ECPT_ST_OSB_HI:ECPT_ST_OSA_LO];
         end
         if (wr_mk) begin
            int_mask_ff <= wbyte[ECPT_ST_MATCH_B:ECPT_ST_OVF];
         end
      end
   end
endmodule : ecpt_timer

// ### bench/ecpt_pin_model.sv
`timescale 1ns/100ps
// ----
// Far side pins
// ----
module ecpt_pin_model (
   input wire logic pclk,
   output logic ext_clock_pin,
   output logic counter_reset_pin,
   output logic trigger_input_pin
);
   initial begin
      ext_clock_pin = 1'b0;
      counter_reset_pin = 1'b0;
      trigger_input_pin = 1'b1;
   end
   // Level held two cycles after each change
   task automatic drive(input int sel, input logic v);
      @(posedge pclk);
      if (sel == 0) ext_clock_pin <= v;
      else trigger_input_pin <= v;
      repeat (2) @(posedge pclk);
   endtask : drive
endmodule : ecpt_pin_model

// ### bench/ecpt_timer_props.sv
`timescale 1ns/100ps
// ----
// Port checks
// ----
module ecpt_timer_props
   import ecpt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pulse_output_pin,
   input wire logic irq
);
   wire acc = psel && penable;
   wire rd_acc = acc && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_always: assert property (pready) else $error("pready low");
   a_reset_quiet: assert property ($rose(presetn) |-> !pulse_output_pin && !irq)
      else $error("pin or irq high after reset");
   a_unmapped_err: assert property (acc && paddr > 8'h18 |-> pslverr)
      else $error("no error on unmapped access");
   a_mapped_ok: assert property (acc && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped access");
   a_unmapped_zero: assert property (rd_acc && pslverr |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (rd_acc |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_ctrl1_ones: assert property (rd_acc && paddr == ECPT_OFF_CTRL1 |-> prdata[7:5] == 3'h7 && prdata[1])
      else $error("reserved bits not one");
   a_const_write: assert property (acc && pwrite && paddr == ECPT_OFF_CONST_A ##3
      rd_acc && paddr == ECPT_OFF_CONST_A |-> prdata == ($past(pwdata, 3) & 32'hff))
      else $error("constant write lost");
   a_mask_gate: assert property (acc && pwrite && paddr == ECPT_OFF_MASK && pwdata[7:5] == 3'h0
      |=> !irq) else $error("irq with all masked");
endmodule : ecpt_timer_props

bind ecpt_timer ecpt_timer_props u_ecpt_timer_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_output_pin, .irq);

// ### bench/tb_top.sv
`timescale 1ns/100ps
// ----
// Bench
// ----
module tb_top
   import ecpt_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, ext_clock_pin, counter_reset_pin, trigger_input_pin;
   logic pulse_output_pin, irq, m_pin, m_trg, m_run;
   logic [7:0] rd, rv;
   integer seed = 32'h68c3f6cf;
   int failures = 0;
   int n_checks = 0;
   int m_cnt, m_a, m_b, m_clr, m_osa, m_osb, m_st;
   logic [7:0] rst_tab [7] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'he2, 8'h00};
   always #20 pclk = ~pclk;
   ecpt_timer u_ecpt_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ext_clock_pin, .counter_reset_pin, .trigger_input_pin,
      .pulse_output_pin, .irq);
   ecpt_pin_model u_ecpt_pin_model (.pclk, .ext_clock_pin, .counter_reset_pin,
      .trigger_input_pin);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic void step(input logic sup_a);
      logic ma;
      logic mb;
      if (m_trg && !m_run) return;
      ma = m_cnt == m_a && !sup_a;
      mb = m_cnt == m_b;
      if ((ma && m_osa == 3) || (mb && m_osb == 3)) m_pin = ~m_pin;
      else if ((ma && m_osa == 2) || (mb && m_osb == 2)) m_pin = 1'b1;
      else if ((ma && m_osa == 1) || (mb && m_osb == 1)) m_pin = 1'b0;
      m_st = m_st | {24'h0, mb, ma, 6'h0};
      if ((m_clr == 1 && ma) || (m_clr == 2 && mb)) begin
         m_cnt = 0;
         m_run = 1'b0;
      end else begin
         if (m_cnt == 255) m_st = m_st | 32'h20;
         m_cnt = (m_cnt + 1) % 256;
      end
   endfunction : step
   task automatic tick();
      u_ecpt_pin_model.drive(0, 1'b1);
      u_ecpt_pin_model.drive(0, 1'b0);
      step(1'b0);
   endtask : tick
   task automatic cfg(input int clr, a, b, osa, osb, cnt);
      m_clr = clr;
      m_a = a;
      m_b = b;
      m_osa = osa;
      m_osb = osb;
      m_cnt = cnt;
      m_st = 0;
      apb(1'b1, ECPT_OFF_CTRL0, {3'h0, clr[1:0], ECPT_CKS_EXT_FALL});
      apb(1'b1, ECPT_OFF_CONST_A, a[7:0]);
      apb(1'b1, ECPT_OFF_CONST_B, b[7:0]);
      apb(1'b1, ECPT_OFF_STATUS, {3'h7, 1'b0, osb[1:0], osa[1:0]});
      apb(1'b1, ECPT_OFF_COUNT, cnt[7:0]);
   endtask : cfg
   task automatic verify();
      apb(1'b0, ECPT_OFF_COUNT, 8'h00);
      chk(rd, m_cnt[7:0]);
      apb(1'b0, ECPT_OFF_STATUS, 8'h00);
      chk(rd, {m_st[7:5], 1'b0, m_osb[1:0], m_osa[1:0]});
      chk({7'h0, pulse_output_pin}, {7'h0, m_pin});
   endtask : verify
   task automatic hit(input logic [7:0] a, input logic [7:0] d, input logic sup);
      u_ecpt_pin_model.drive(0, 1'b1);
      fork
         apb(1'b1, a, d);
         begin
            @(posedge pclk);
            u_ecpt_pin_model.drive(0, 1'b0);
         end
      join
      step(sup);
   endtask : hit
   task automatic complete_run();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   initial begin
      #400000;
      failures++;
      complete_run();
   end
   initial begin
      m_pin = 1'b0;
      m_trg = 1'b0;
      m_run = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({7'h0, pulse_output_pin}, 8'h00);
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, 8'(i * 4), 8'h00);
         chk(rd, rst_tab[i]);
      end
      apb(1'b0, 8'h1c, 8'h00);
      chk(rd, 8'h00);
      rv = 8'($random(seed));
      apb(1'b1, ECPT_OFF_CONST_A, rv);
      apb(1'b0, ECPT_OFF_CONST_A, 8'h00);
      chk(rd, rv);
      for (int i = 0; i < 3; i++) begin
         cfg(0, 255, 255, 0, 0, 8'($random(seed)));
         repeat (1 + ($unsigned($random(seed)) % 4)) tick();
         verify();
      end
      cfg(0, 16, 16, 0, 0, 254);
      apb(1'b1, ECPT_OFF_MASK, 8'h20);
      repeat (2) tick();
      verify();
      chk({7'h0, irq}, 8'h01);
      apb(1'b1, ECPT_OFF_MASK, 8'h00);
      @(negedge pclk);
      chk({7'h0, irq}, 8'h00);
      apb(1'b1, ECPT_OFF_MASK, 8'h20);
      apb(1'b1, ECPT_OFF_STATUS, 8'h20);
      @(negedge pclk);
      chk({7'h0, irq}, 8'h00);
      for (int oa = 0; oa < 4; oa++) begin
         for (int ob = 0; ob < 4; ob++) begin
            cfg(0, 80, 80, oa, ob, 80);
            tick();
            verify();
         end
      end
      cfg(0, 255, 255, 0, 0, 32);
      hit(ECPT_OFF_COUNT, 8'h77, 1'b0);
      m_cnt = 8'h77;
      verify();
      cfg(1, 48, 255, 0, 0, 48);
      hit(ECPT_OFF_COUNT, 8'h77, 1'b0);
      verify();
      cfg(0, 48, 255, 2, 0, 48);
      hit(ECPT_OFF_CONST_A, 8'h30, 1'b1);
      verify();
      cfg(0, 255, 255, 0, 0, 0);
      apb(1'b1, ECPT_OFF_CTRL0, 8'h01);
      repeat (20) @(posedge pclk);
      apb(1'b1, ECPT_OFF_CTRL0, 8'h00);
      apb(1'b0, ECPT_OFF_COUNT, 8'h00);
      chk({7'h0, (rd >= 8'd10) && (rd <= 8'd13)}, 8'h01);
      cfg(1, 4, 2, 2, 1, 0);
      repeat (12) begin
         tick();
         chk({7'h0, pulse_output_pin}, {7'h0, m_pin});
      end
      cfg(2, 2, 5, 2, 1, 0);
      apb(1'b1, ECPT_OFF_CTRL1, 8'h14);
      m_trg = 1'b1;
      repeat (2) tick();
      verify();
      u_ecpt_pin_model.drive(1, 1'b0);
      u_ecpt_pin_model.drive(1, 1'b1);
      m_run = 1'b1;
      repeat (8) begin
         tick();
         chk({7'h0, pulse_output_pin}, {7'h0, m_pin});
      end
      verify();
      complete_run();
   end
endmodule : tb_top
